// ===== bench/lin_node_model.sv
// remote serial node driving the receive line
`timescale 1ns/1ps
`default_nettype none
module lin_node_model (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n * 8) @(posedge clk);
  endtask
  task automatic send_byte(input logic [7:0] d);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(d[i], 1);
    hold(1'b1, 1);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_usart_lin_break_sync_master.sv
// self-checking bench for the lin-capable serial transceiver
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb_usart_lin_break_sync_master;
  import usart_lin_pkg::*;
  localparam int PS = 1;
  localparam int BT = 8;
  localparam int ABD_EXP = 8 * BT / PS + 1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, rxdtIn, rxdtOut, rxdtOe, txckOut, txckOe, wakeRequest, nodeLine;
  int checks = 0;
  int bad_count = 0;
  assign rxdtIn = rxdtOe ? rxdtOut : nodeLine;
  initial forever #5 clk = ~clk;
  usart_lin_break_sync_master #(.PRESCALE(PS)) usart_lin_break_sync_master_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxdtIn(rxdtIn), .rxdtOut(rxdtOut), .rxdtOe(rxdtOe), .txckOut(txckOut),
    .txckOe(txckOe), .wakeRequest(wakeRequest));
  lin_node_model lin_node_model_i (.clk(clk), .line(nodeLine));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic give_up(input string s);
    bad_count++;
    $display("MISMATCH %s expected done seen timeout", s);
    complete_run();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) give_up("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic bitchk(input string nm, input logic [7:0] a, input int p, input logic x);
    logic [31:0] r;
    rd(a, r);
    `CHK(nm, x, r[p])
  endtask
  task automatic cap(input int n, output logic [15:0] b);
    int k;
    k = 0;
    b = 16'h0;
    while (txckOut !== 1'b0) begin
      @(posedge clk);
      k++;
      if (k > 2000) give_up("frame start");
    end
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BT) @(posedge clk);
      b[i] = txckOut;
    end
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    repeat (20) @(posedge clk);
    `CHK("reset pins", 4'b1000, {txckOut, txckOe, rxdtOe, wakeRequest})
    rst_n <= 1'b1;
    rd(RATE_OFF, r);
    `CHK("rate reset", {16'h0, RATE_RESET}, r)
    apb(1'b0, 8'h1c, 32'h0, r, e);
    `CHK("unmapped", 33'h100000000, {e, r})
    $display("reset finished");
  endtask
  task automatic t_tx(input logic brk);
    logic [15:0] a, b;
    wr(RATE_OFF, 32'h7);
    wr(RX_CTRL_OFF, 32'h80);
    wr(TX_CTRL_OFF, brk ? 32'h28 : 32'h20);
    fork
      begin
        cap(brk ? 14 : 10, a);
        cap(10, b);
      end
      begin
        wr(TX_DATA_OFF, 32'ha5);
        wr(TX_DATA_OFF, brk ? 32'h55 : 32'h3c);
        bitchk("buffer empty", FLAGS_OFF, 1, 1'b0);
        bitchk("shift empty", TX_CTRL_OFF, 1, 1'b0);
        bitchk("break bit", TX_CTRL_OFF, 3, brk);
      end
    join
    if (brk) `CHK("break frame", {1'b1, 13'h0000}, a[13:0])
    else `CHK("first frame", {1'b1, 8'ha5, 1'b0}, a[9:0])
    `CHK("second frame", {1'b1, brk ? 8'h55 : 8'h3c, 1'b0}, b[9:0])
    repeat (BT) @(posedge clk);
    bitchk("buffer empty", FLAGS_OFF, 1, 1'b1);
    bitchk("shift empty", TX_CTRL_OFF, 1, 1'b1);
    bitchk("break bit", TX_CTRL_OFF, 3, 1'b0);
    $display("transmit finished");
  endtask
  task automatic t_rx_break();
    logic [31:0] r;
    wr(TX_CTRL_OFF, 32'h0);
    wr(RX_CTRL_OFF, 32'h90);
    lin_node_model_i.hold(1'b0, 13);
    lin_node_model_i.hold(1'b1, 2);
    bitchk("break flag", FLAGS_OFF, 0, 1'b1);
    bitchk("framing", RX_CTRL_OFF, 2, 1'b1);
    rd(RX_DATA_OFF, r);
    `CHK("break data", 8'h00, r[7:0])
    bitchk("flag cleared", FLAGS_OFF, 0, 1'b0);
    $display("break receive finished");
  endtask
  task automatic t_wake();
    logic [31:0] r;
    bitchk("idle first", BAUD_CTRL_OFF, 6, 1'b1);
    wr(BAUD_CTRL_OFF, 32'h2);
    repeat (2) @(posedge clk);
    fork
      lin_node_model_i.hold(1'b0, 13);
      begin
        repeat (20) @(posedge clk);
        `CHK("wake request", 1'b1, wakeRequest)
        bitchk("wake flag", FLAGS_OFF, 0, 1'b1);
        rd(RX_DATA_OFF, r);
        bitchk("wake read", FLAGS_OFF, 0, 1'b0);
      end
    join
    lin_node_model_i.hold(1'b1, 2);
    bitchk("wake enable", BAUD_CTRL_OFF, 1, 1'b0);
    `CHK("wake released", 1'b0, wakeRequest)
    bitchk("no char", FLAGS_OFF, 0, 1'b0);
    lin_node_model_i.send_byte(8'h3c);
    lin_node_model_i.hold(1'b1, 1);
    bitchk("next byte", FLAGS_OFF, 0, 1'b1);
    rd(RX_DATA_OFF, r);
    `CHK("next data", 8'h3c, r[7:0])
    wr(BAUD_CTRL_OFF, 32'h2);
    repeat (2) @(posedge clk);
    lin_node_model_i.send_byte(8'h01);
    lin_node_model_i.hold(1'b1, 2);
    bitchk("fragment wake", BAUD_CTRL_OFF, 1, 1'b0);
    rd(RX_DATA_OFF, r);
    `CHK("fragment data", 8'hc0, r[7:0])
    $display("wake finished");
  endtask
  task automatic t_autobaud();
    logic [31:0] r;
    wr(BAUD_CTRL_OFF, 32'h1);
    lin_node_model_i.send_byte(8'h55);
    lin_node_model_i.hold(1'b1, 2);
    rd(RATE_OFF, r);
    `CHK("rate count", 1'b1, r >= ABD_EXP - 2 && r <= ABD_EXP + 2)
    bitchk("abd cleared", BAUD_CTRL_OFF, 0, 1'b0);
    bitchk("abd flag", FLAGS_OFF, 0, 1'b1);
    rd(RX_DATA_OFF, r);
    wr(BAUD_CTRL_OFF, 32'h1);
    lin_node_model_i.hold(1'b0, 1);
    lin_node_model_i.hold(1'b1, 8250);
    bitchk("overflow", BAUD_CTRL_OFF, 7, 1'b1);
    bitchk("busy", BAUD_CTRL_OFF, 6, 1'b0);
    bitchk("ovf flag", FLAGS_OFF, 0, 1'b1);
    rd(RX_DATA_OFF, r);
    bitchk("ovf read", FLAGS_OFF, 0, 1'b0);
    repeat (4) begin
      lin_node_model_i.hold(1'b0, 1);
      lin_node_model_i.hold(1'b1, 1);
    end
    bitchk("fifth edge", FLAGS_OFF, 0, 1'b1);
    bitchk("idle again", BAUD_CTRL_OFF, 6, 1'b1);
    bitchk("abd done", BAUD_CTRL_OFF, 0, 1'b0);
    wr(BAUD_CTRL_OFF, 32'h0);
    bitchk("ovf clear", BAUD_CTRL_OFF, 7, 1'b0);
    rd(RX_DATA_OFF, r);
    wr(RATE_OFF, 32'h7);
    wr(BAUD_CTRL_OFF, 32'h1);
    lin_node_model_i.hold(1'b0, 1);
    lin_node_model_i.hold(1'b1, 1);
    wr(BAUD_CTRL_OFF, 32'h0);
    lin_node_model_i.send_byte(8'h5a);
    lin_node_model_i.hold(1'b1, 1);
    bitchk("early stop flag", FLAGS_OFF, 0, 1'b1);
    rd(RX_DATA_OFF, r);
    `CHK("early stop data", 8'h5a, r[7:0])
    $display("autobaud finished");
  endtask
  task automatic t_sync();
    logic [7:0] got;
    logic p, ck;
    int edges;
    for (int q = 0; q < 2; q++) begin
      p = q[0];
      edges = 0;
      got = 8'h0;
      wr(BAUD_CTRL_OFF, {27'h0, p, 4'h0});
      wr(RX_CTRL_OFF, 32'h80);
      wr(TX_CTRL_OFF, 32'hb0);
      repeat (3) @(posedge clk);
      `CHK("clock idle", p, txckOut)
      `CHK("drivers on", 2'b11, {txckOe, rxdtOe})
      ck = txckOut;
      fork
        wr(TX_DATA_OFF, 32'h96);
        repeat (400) begin
          @(posedge clk);
          if (ck === p && txckOut === !p) edges++;
          if (ck === !p && txckOut === p) got = {rxdtOut, got[7:1]};
          ck = txckOut;
        end
      join
      `CHK("clock count", 8, edges)
      `CHK("sync byte", 8'h96, got)
    end
    wr(RX_CTRL_OFF, 32'ha0);
    repeat (3) @(posedge clk);
    `CHK("receive mode", 1'b0, rxdtOe)
    wr(TX_CTRL_OFF, 32'h0);
    wr(BAUD_CTRL_OFF, 32'h0);
    $display("sync finished");
  endtask
  initial begin
    t_reset();
    t_tx(1'b0);
    t_tx(1'b1);
    t_rx_break();
    t_wake();
    t_autobaud();
    t_sync();
    complete_run();
  end
endmodule
bind usart_lin_break_sync_master usart_lin_chk usart_lin_chk_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxdtIn(rxdtIn),
  .rxdtOe(rxdtOe), .txckOe(txckOe), .wakeRequest(wakeRequest));
`default_nettype wire

// ===== bench/usart_lin_chk.sv
// port assertions for the lin-capable serial transceiver
`timescale 1ns/1ps
`default_nettype none
module usart_lin_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usart_lin_pkg::ADDR_W-1:0] paddr,
  input wire logic [usart_lin_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxdtIn,
  input wire logic rxdtOe,
  input wire logic txckOe,
  input wire logic wakeRequest
);
  import usart_lin_pkg::*;
  logic wrDone;
  assign wrDone = psel && penable && pready && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > FLAGS_OFF))
    else $error("pslverr does not match address map");
  chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
    else $error("refused access returned data");
  chk_oe_pair: assert property (rxdtOe |-> txckOe)
    else $error("data driven without clock driven");
  chk_oe_mode: assert property ($rose(rxdtOe) |->
    $past(wrDone) || $past(wrDone, 2) || $past(wrDone, 3))
    else $error("data driver enabled without a write");
  chk_wake_fall: assert property ($rose(wakeRequest) |-> !rxdtIn)
    else $error("wake raised without low line");
  chk_wake_clear: assert property ($rose(rxdtIn) && wakeRequest |-> ##[1:8] !wakeRequest)
    else $error("wake not cleared after rising line");
  cover property (pready && pslverr);
  cover property ($rose(wakeRequest));
  cover property ($rose(rxdtOe));
endmodule
`default_nettype wire

// ===== common/usart_lin_pkg.sv
// shared constants and register layouts of the lin-capable serial transceiver
package usart_lin_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RATE_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] BAUD_CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] TX_CTRL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] RX_CTRL_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] TX_DATA_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] RX_DATA_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] RATE_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] FLAGS_OFF = 8'h18;

  // field positions in written words
  localparam int ABD_EN_POS = 0;
  localparam int WAKE_EN_POS = 1;
  localparam int POL_POS = 4;
  localparam int OVF_POS = 7;
  localparam int SEND_BREAK_BIT_POS = 3;
  localparam int SYNC_POS = 4;
  localparam int TRANSMIT_ENABLE_BIT_POS = 5;
  localparam int CLOCK_SOURCE_MASTER_POS = 7;
  localparam int CONTINUOUS_RECEIVE_ENABLE_POS = 4;
  localparam int SINGLE_RECEIVE_ENABLE_POS = 5;
  localparam int SERIAL_PORT_ENABLE_POS = 7;

  // reset values
  localparam logic [RATE_W-1:0] RATE_RESET = 16'h0000;
  localparam logic [7:0] RX_DATA_RESET = 8'h00;

  // frame shapes and counts
  localparam logic [3:0] BITS_ASYNC = 4'ha;
  localparam logic [3:0] BITS_BREAK = 4'he;
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [13:0] BREAK_FRAME = 14'h2000;
  localparam logic [2:0] ABD_LAST_EDGE = 3'h4;
  localparam logic [RATE_W-1:0] ABD_START = 16'h0001;
  localparam logic [RATE_W-1:0] RATE_MAX = 16'hffff;
  localparam int ABD_PRESCALE = 8;

  typedef struct packed {
    logic overflow;
    logic rxIdle;
    logic rsv5;
    logic clockPolarity;
    logic [1:0] rsv3;
    logic wakeEnable;
    logic autobaudEnable;
  } baud_ctrl_t;

  typedef struct packed {
    logic clockSource;
    logic rsv6;
    logic transmitEnable;
    logic syncMode;
    logic sendBreak;
    logic rsv2;
    logic shiftEmpty;
    logic rsv0;
  } tx_ctrl_t;

  typedef struct packed {
    logic portEnable;
    logic rsv6;
    logic singleRx;
    logic contRx;
    logic rsv3;
    logic framingError;
    logic [1:0] rsv0;
  } rx_ctrl_t;
endpackage

// ===== hdl/usart_lin_break_sync_master.sv
// serial transceiver with auto-baud, wake on break, break send and sync master transmit
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module usart_lin_break_sync_master #(
  parameter int PRESCALE = usart_lin_pkg::ABD_PRESCALE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usart_lin_pkg::ADDR_W-1:0] paddr,
  input wire logic [usart_lin_pkg::DATA_W-1:0] pwdata,
  output logic [usart_lin_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxdtIn,
  output logic rxdtOut,
  output logic rxdtOe,
  output logic txckOut,
  output logic txckOe,
  output logic wakeRequest
);
  import usart_lin_pkg::*;

  localparam int PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [1:0] {AB_IDLE, AB_START, AB_FIRST, AB_COUNT} ab_state_t;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  function automatic logic expired(input logic [RATE_W-1:0] t);
    return t == '0;
  endfunction

  logic rxMeta, rxSync, rxPrev;
  logic preadyReg, pslverrReg;
  logic [DATA_W-1:0] prdataReg, readWord;
  logic abdEnReg, wakeEnReg, polReg, ovfReg;
  logic csrcReg, txenReg, syncReg, sendbReg;
  logic spenReg, srenReg, crenReg, ferrReg;
  logic [RATE_W-1:0] rateReg;
  logic [7:0] rxDataReg, rxShift;
  logic rcifReg;
  rx_state_t rxState;
  logic [RATE_W-1:0] rxTmr;
  logic [3:0] rxBit;
  ab_state_t abState;
  logic [RATE_W-1:0] abCnt;
  logic [PRE_W-1:0] abPre;
  logic [2:0] abEdges;
  logic armReg, wakePrev, wakeSeen, wakeFlag;
  logic [7:0] txBufReg;
  logic txBufFull, txBusy, txBreak, txHalf, lineReg, clkReg;
  logic [13:0] txShift, txFrame;
  logic [3:0] txLeft;
  logic [RATE_W-1:0] txTmr;
  logic txckOutReg, txckOeReg, rxdtOutReg, rxdtOeReg;
  baud_ctrl_t baudView;
  tx_ctrl_t txView;
  rx_ctrl_t rxView;

  // receive line into the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= rxdtIn;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end

  wire rxFall = rxPrev & ~rxSync;
  wire rxRise = ~rxPrev & rxSync;

  // apb slave, one wait state
  wire accessWait = psel & penable & ~preadyReg;
  wire xferDone = psel & penable & preadyReg;
  wire wrDone = xferDone & pwrite;
  wire rdDone = xferDone & ~pwrite;
  wire mapped = hit(paddr, BAUD_CTRL_OFF) | hit(paddr, TX_CTRL_OFF) | hit(paddr, RX_CTRL_OFF) |
                hit(paddr, TX_DATA_OFF) | hit(paddr, RX_DATA_OFF) | hit(paddr, RATE_OFF) |
                hit(paddr, FLAGS_OFF);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg <= '0;
    end else begin
      preadyReg <= accessWait;
      if (accessWait) begin
        pslverrReg <= ~mapped;
        prdataReg <= readWord;
      end
    end
  end

  // mode decode
  wire asyncMode = spenReg & ~syncReg;
  wire syncMasterTx = spenReg & syncReg & csrcReg & ~srenReg & ~crenReg;
  wire abEnable = abdEnReg & ~wakeEnReg;
  wire rxEnable = asyncMode & crenReg & ~wakeEnReg & (abState == AB_IDLE);
  wire rxIdle = (rxState == RX_IDLE) & (abState != AB_FIRST) & (abState != AB_COUNT);
  wire abPreTick = (abPre == PRE_W'(PRESCALE - 1));
  wire abDone = (abState == AB_COUNT) & rxRise & (abEdges == ABD_LAST_EDGE);
  wire abOvf = (abState == AB_COUNT) & abPreTick & (abCnt == RATE_MAX);
  wire rxDone = rxEnable & (rxState == RX_STOP) & expired(rxTmr);
  wire wakeRise = wakeSeen & ~wakePrev;
  wire wakeEnd = wakeEnReg & wakeSeen & rxRise;
  wire txLoad = ~txBusy & txBufFull & txenReg & (asyncMode | syncMasterTx);
  wire txLast = txBusy & expired(txTmr) & (txLeft == 4'h1) & (~syncReg | txHalf);
  wire breakDone = txLast & txBreak;

  always_comb begin
    baudView = '0;
    baudView.overflow = ovfReg;
    baudView.rxIdle = rxIdle;
    baudView.clockPolarity = polReg;
    baudView.wakeEnable = wakeEnReg;
    baudView.autobaudEnable = abdEnReg;
    txView = '0;
    txView.clockSource = csrcReg;
    txView.transmitEnable = txenReg;
    txView.syncMode = syncReg;
    txView.sendBreak = sendbReg;
    txView.shiftEmpty = ~txBusy;
    rxView = '0;
    rxView.portEnable = spenReg;
    rxView.singleRx = srenReg;
    rxView.contRx = crenReg;
    rxView.framingError = ferrReg;
    readWord = '0;
    if (hit(paddr, BAUD_CTRL_OFF)) begin
      readWord[7:0] = baudView;
    end else if (hit(paddr, TX_CTRL_OFF)) begin
      readWord[7:0] = txView;
    end else if (hit(paddr, RX_CTRL_OFF)) begin
      readWord[7:0] = rxView;
    end else if (hit(paddr, RX_DATA_OFF)) begin
      readWord[7:0] = rxDataReg;
    end else if (hit(paddr, RATE_OFF)) begin
      readWord[RATE_W-1:0] = rateReg;
    end else if (hit(paddr, FLAGS_OFF)) begin
      readWord[1:0] = {~txBufFull, rcifReg};
    end
  end

  // baud control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abdEnReg <= 1'b0;
      wakeEnReg <= 1'b0;
      polReg <= 1'b0;
      ovfReg <= 1'b0;
    end else begin
      if (wrDone & hit(paddr, BAUD_CTRL_OFF)) begin
        abdEnReg <= pwdata[ABD_EN_POS];
        wakeEnReg <= pwdata[WAKE_EN_POS];
        polReg <= pwdata[POL_POS];
        if (!pwdata[OVF_POS]) begin
          ovfReg <= 1'b0;
        end
      end
      if (abDone) begin
        abdEnReg <= 1'b0;
      end
      if (wakeEnd) begin
        wakeEnReg <= 1'b0;
      end
      if (abOvf) begin
        ovfReg <= 1'b1;
      end
    end
  end

  // transmit and receive control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csrcReg <= 1'b0;
      txenReg <= 1'b0;
      syncReg <= 1'b0;
      sendbReg <= 1'b0;
      spenReg <= 1'b0;
      srenReg <= 1'b0;
      crenReg <= 1'b0;
    end else begin
      if (wrDone & hit(paddr, TX_CTRL_OFF)) begin
        csrcReg <= pwdata[CLOCK_SOURCE_MASTER_POS];
        txenReg <= pwdata[TRANSMIT_ENABLE_BIT_POS];
        syncReg <= pwdata[SYNC_POS];
        sendbReg <= pwdata[SEND_BREAK_BIT_POS];
      end
      if (breakDone) begin
        sendbReg <= 1'b0;
      end
      if (wrDone & hit(paddr, RX_CTRL_OFF)) begin
        spenReg <= pwdata[SERIAL_PORT_ENABLE_POS];
        srenReg <= pwdata[SINGLE_RECEIVE_ENABLE_POS];
        crenReg <= pwdata[CONTINUOUS_RECEIVE_ENABLE_POS];
      end
    end
  end

  // rate counter: software value or auto-baud result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rateReg <= RATE_RESET;
    end else if (abDone) begin
      rateReg <= abCnt;
    end else if (wrDone & hit(paddr, RATE_OFF)) begin
      rateReg <= pwdata[RATE_W-1:0];
    end
  end

  // receive flag, hardware set wins over read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcifReg <= 1'b0;
    end else if (rxDone | abDone | abOvf | wakeRise) begin
      rcifReg <= 1'b1;
    end else if (rdDone & hit(paddr, RX_DATA_OFF)) begin
      rcifReg <= 1'b0;
    end
  end

  // auto-baud measurement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abState <= AB_IDLE;
      abCnt <= '0;
      abPre <= '0;
      abEdges <= '0;
    end else if (!abEnable) begin
      abState <= AB_IDLE;
    end else begin
      unique case (abState)
        AB_IDLE: begin
          abState <= AB_START;
        end
        AB_START: begin
          if (rxFall) begin
            abState <= AB_FIRST;
          end
        end
        AB_FIRST: begin
          if (rxRise) begin
            abState <= AB_COUNT;
            abCnt <= ABD_START;
            abPre <= '0;
            abEdges <= 3'h1;
          end
        end
        AB_COUNT: begin
          if (rxRise) begin
            abEdges <= abEdges + 3'h1;
          end
          if (abDone) begin
            abState <= AB_IDLE;
          end
          if (abPreTick) begin
            abPre <= '0;
            abCnt <= abCnt + 16'h0001;
          end else begin
            abPre <= abPre + PRE_W'(1);
          end
        end
      endcase
    end
  end

  // asynchronous receiver, sampled mid-bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      rxTmr <= '0;
      rxBit <= '0;
      rxShift <= '0;
    end else if (!rxEnable) begin
      rxState <= RX_IDLE;
    end else if (rxState == RX_IDLE) begin
      if (rxFall) begin
        rxState <= RX_START;
        rxTmr <= rateReg >> 1;
      end
    end else if (!expired(rxTmr)) begin
      rxTmr <= rxTmr - 16'h0001;
    end else begin
      rxTmr <= rateReg;
      unique case (rxState)
        RX_START: begin
          rxBit <= '0;
          rxState <= rxSync ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          rxShift <= {rxSync, rxShift[7:1]};
          rxBit <= rxBit + 4'h1;
          if (rxBit == DATA_BITS - 4'h1) begin
            rxState <= RX_STOP;
          end
        end
        default: begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxDataReg <= RX_DATA_RESET;
      ferrReg <= 1'b0;
    end else if (rxDone) begin
      rxDataReg <= rxShift;
      ferrReg <= ~rxSync;
    end
  end

  // wake on break
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armReg <= 1'b0;
      wakePrev <= 1'b0;
    end else begin
      armReg <= wakeEnReg & asyncMode & ~wakeEnd;
      wakePrev <= wakeSeen;
    end
  end

  wake_detector wake_detector_i (
    .clk(clk),
    .rst_n(rst_n),
    .rxPin(rxdtIn),
    .armed(armReg),
    .wakeFlag(wakeFlag),
    .wakeSeen(wakeSeen)
  );

  // transmit buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBufFull <= 1'b0;
      txBufReg <= '0;
    end else begin
      if (txLoad) begin
        txBufFull <= 1'b0;
      end
      if (wrDone & hit(paddr, TX_DATA_OFF) & txenReg) begin
        txBufFull <= 1'b1;
        txBufReg <= pwdata[7:0];
      end
    end
  end

  always_comb begin
    if (syncReg) begin
      txFrame = {6'h00, txBufReg};
    end else if (sendbReg) begin
      txFrame = BREAK_FRAME;
    end else begin
      txFrame = {4'h0, 1'b1, txBufReg, 1'b0};
    end
  end

  // transmit shifter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBusy <= 1'b0;
      txBreak <= 1'b0;
      txHalf <= 1'b0;
      txShift <= '0;
      txLeft <= '0;
      txTmr <= '0;
      lineReg <= 1'b1;
      clkReg <= 1'b0;
    end else if (!spenReg) begin
      txBusy <= 1'b0;
      lineReg <= 1'b1;
      clkReg <= polReg;
    end else if (txLoad) begin
      txBusy <= 1'b1;
      txBreak <= ~syncReg & sendbReg;
      txHalf <= 1'b0;
      txTmr <= rateReg;
      lineReg <= txFrame[0];
      txShift <= txFrame >> 1;
      txLeft <= syncReg ? BITS_SYNC : (sendbReg ? BITS_BREAK : BITS_ASYNC);
      clkReg <= syncReg ? ~polReg : polReg;
    end else if (txBusy) begin
      if (!expired(txTmr)) begin
        txTmr <= txTmr - 16'h0001;
      end else begin
        txTmr <= rateReg;
        if (syncReg & ~txHalf) begin
          txHalf <= 1'b1;
          clkReg <= polReg;
        end else if (txLast) begin
          txBusy <= 1'b0;
          lineReg <= 1'b1;
          clkReg <= polReg;
        end else begin
          txLeft <= txLeft - 4'h1;
          lineReg <= txShift[0];
          txShift <= txShift >> 1;
          txHalf <= 1'b0;
          clkReg <= syncReg ? ~polReg : polReg;
        end
      end
    end else begin
      clkReg <= polReg;
    end
  end

  // pin drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txckOutReg <= 1'b1;
      txckOeReg <= 1'b0;
      rxdtOutReg <= 1'b1;
      rxdtOeReg <= 1'b0;
    end else begin
      txckOutReg <= syncReg ? clkReg : lineReg;
      txckOeReg <= spenReg & (syncReg ? csrcReg : txenReg);
      rxdtOutReg <= lineReg;
      rxdtOeReg <= syncMasterTx;
    end
  end

  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = pslverrReg;
  assign txckOut = txckOutReg;
  assign txckOe = txckOeReg;
  assign rxdtOut = rxdtOutReg;
  assign rxdtOe = rxdtOeReg;
  assign wakeRequest = wakeFlag;
endmodule
`default_nettype wire

// ===== hdl/wake_detector.sv
// clockless falling-edge catcher for the receive line, with its crossing
`timescale 1ns/1ps
`default_nettype none
module wake_detector (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rxPin,
  input wire logic armed,
  output logic wakeFlag,
  output logic wakeSeen
);
  import usart_lin_pkg::*;

  logic flagMeta;

  // clocked by the line itself, works with module clocks stopped
  always_ff @(negedge rxPin or negedge armed) begin
    if (!armed) begin
      wakeFlag <= 1'b0;
    end else begin
      wakeFlag <= 1'b1;
    end
  end

  // two-stage crossing into the bus clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagMeta <= 1'b0;
      wakeSeen <= 1'b0;
    end else begin
      flagMeta <= wakeFlag;
      wakeSeen <= flagMeta;
    end
  end
endmodule
`default_nettype wire
